//--- include/cdr_map.svh
// register offsets, field positions and reset values of the dac register bank
`ifndef CDR_MAP_SVH
`define CDR_MAP_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define CDR_FRAME_W       24
`define CDR_ADDR_MSB      23
`define CDR_ADDR_LSB      16
`define CDR_DATA_MSB      15
`define CDR_CNT_W         5

// ----------------------------------------------------------------
// write addresses
// ----------------------------------------------------------------
`define CDR_ADDR_NOP      8'h00
`define CDR_ADDR_DATA     8'h01
`define CDR_ADDR_READ     8'h02
`define CDR_ADDR_RESET    8'h56
`define CDR_ADDR_CONFIG   8'h57
`define CDR_ADDR_GAIN     8'h58
`define CDR_ADDR_ZERO     8'h59

// ----------------------------------------------------------------
// readback selects, low bits of a read frame's data
// ----------------------------------------------------------------
`define CDR_RD_SEL_W      3
`define CDR_RD_STATUS     3'h0
`define CDR_RD_DATA       3'h1
`define CDR_RD_CONFIG     3'h2
`define CDR_RD_GAIN       3'h3
`define CDR_RD_ZERO       3'h4

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CDR_RST_BIT       0
`define CDR_CALIBRATION_ENABLE_BIT     5
`define CDR_ST_CRC        4
`define CDR_ST_WD         3
`define CDR_ST_LOAD       2
`define CDR_ST_SLEW       1
`define CDR_ST_TEMP       0

// ----------------------------------------------------------------
// reset values, masks and calibration constants
// ----------------------------------------------------------------
`define CDR_WORD_RST      16'h0000
`define CDR_FRAME_RST     24'h000000
`define CDR_MASK_16B      16'hFFFF
`define CDR_MASK_12B      16'hFFF0
`define CDR_GAIN_BIAS     17'h08000
`define CDR_CODE_MAX      16'hFFFF

`endif

//--- include/cdr_pkg.sv
// shared types of the dac register bank
`default_nettype none
package cdr_pkg;
    typedef logic [15:0] cdr_word_t;
    typedef logic [23:0] cdr_frame_t;
    typedef logic [7:0]  cdr_addr_t;
    typedef logic [4:0]  cdr_status_t;
endpackage : cdr_pkg
`default_nettype wire

//--- include/cdr_cal_if.sv
// carrier between the register bank and the calibration datapath
`timescale 1ns/1ps
`default_nettype none
interface cdr_cal_if;
    import cdr_pkg::*;
    cdr_word_t code;
    cdr_word_t gain;
    cdr_word_t offset;
    logic      calibration_enable;
    cdr_word_t cal_code;
    modport regs (output code, output gain, output offset, output calibration_enable, input cal_code);
    modport cal  (input code, input gain, input offset, input calibration_enable, output cal_code);
endinterface : cdr_cal_if
`default_nettype wire

//--- hdl/cdr_cal.sv
// calibration datapath: gain and offset trim applied to the output code
`timescale 1ns/1ps
`default_nettype none
`include "cdr_map.svh"
module cdr_cal (
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    cdr_cal_if.cal    bus
);
    import cdr_pkg::*;

    logic [32:0] prod;
    logic [18:0] sum;
    cdr_word_t   cal_nxt;
    cdr_word_t   cal_code_r;

    // scaled code plus signed offset, clamped to the code range
    always_comb begin
        prod = 33'(bus.code) * 33'(17'(bus.gain) + `CDR_GAIN_BIAS);
        sum  = {2'b00, prod[32:16]} + {{3{bus.offset[15]}}, bus.offset};
        if (sum[18]) begin
            cal_nxt = `CDR_WORD_RST;               // below zero
        end else if (sum[17:16] != 2'b00) begin
            cal_nxt = `CDR_CODE_MAX;               // above full scale
        end else begin
            cal_nxt = sum[15:0];
        end
    end

    // registered code, raw when calibration is off
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            cal_code_r <= `CDR_WORD_RST;
        end else if (bus.calibration_enable) begin
            cal_code_r <= cal_nxt;                 // R18
        end else begin
            cal_code_r <= bus.code;
        end
    end

    assign bus.cal_code = cal_code_r;
endmodule : cdr_cal
`default_nettype wire

//--- hdl/cdr_regs.sv
// register bank of a current output dac with serial access and alarm status
//
// Summary of operation
// [R01] output code is 16-bit unsigned binary, cleared to zero at reset
// [R02] gain trim is 16-bit unsigned, cleared to zero at reset
// [R03] offset trim is 16-bit twos complement, cleared to zero at reset
// [R04] software reset register sits at write address 0x56
// [R05] writing one to its bit 0 restores all registers and alarm flags
// [R06] the reset bit clears itself once the reset is done
// [R07] upper fifteen bits of the reset register have no effect
// [R08] status register is read only with four alarms and a slew bit
// [R09] status bits 15 to 5 read as zero
// [R10] bit 4 shows a frame that failed its crc check
// [R11] bit 3 shows an expired watchdog
// [R12] bit 2 shows open circuit or compliance fault on the output
// [R13] bit 1 shows the output code is ramping
// [R14] bit 0 shows die temperature above 142 C
// [R15] output and temperature monitors are watched every cycle
// [R16] a flag stays set until its cause goes or a reset
// [R17] a cleared flag sets again next cycle if the fault persists
// [R18] calibration enable applies gain and offset trim to the code
// [R19] twelve-bit variant keeps bits 15 to 4, low bits read zero
// [R20] reading status returns current flags and clears none
`timescale 1ns/1ps
`default_nettype none
`include "cdr_map.svh"
module cdr_regs #(
    parameter bit P_TWELVE_BIT = 1'b0
) (
    input  wire logic          i_mclk,
    input  wire logic          i_rst_n,
    // serial port, sampled on the system clock
    input  wire logic          i_sclk,
    input  wire logic          i_din,
    input  wire logic          i_latch,
    output logic               o_sdo,
    // fault monitors
    input  wire logic          i_crc_err,
    input  wire logic          i_wd_expired,
    input  wire logic          i_load_fault,
    input  wire logic          i_slewing,
    input  wire logic          i_over_temp,
    // outputs to the converter core
    output cdr_pkg::cdr_word_t  o_output_code,
    output logic               o_calibration_enable,
    output logic               o_soft_reset,
    output cdr_pkg::cdr_status_t o_fault_status
);
    import cdr_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic        sclk_q;
    logic        latch_q;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        latch_rise;
    cdr_frame_t  in_sh_r;
    cdr_frame_t  out_sh_r;
    cdr_frame_t  out_sh_nxt;
    logic        sdo_r;
    logic        frame_wr;
    cdr_addr_t   frame_addr;
    cdr_word_t   frame_data;
    cdr_word_t   wr_mask;
    cdr_word_t   wr_data;
    logic        soft_rst_r;
    logic        clr_all;
    cdr_word_t   output_code_r;
    cdr_word_t   gain_trim_r;
    cdr_word_t   offset_trim_r;
    logic        calibration_enable_r;
    logic        frame_crc_fault_r;
    logic        watchdog_fault_r;
    logic        output_load_fault_r;
    logic        slewing_active_r;
    logic        over_temp_fault_r;
    cdr_status_t status;
    cdr_word_t   status_word;
    cdr_word_t   config_word;
    cdr_word_t   rd_word;

    cdr_cal_if   cal_bus ();

    // ----------------------------------------------------------------
    // serial pin edges
    // ----------------------------------------------------------------

    // previous samples of clock and latch pins
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            sclk_q  <= 1'b0;
            latch_q <= 1'b0;
        end else begin
            sclk_q  <= i_sclk;
            latch_q <= i_latch;
        end
    end

    // one-cycle edge strobes
    // both pins idle low and the samples reset low, so no false edge
    // appears when reset lifts; a pin need hold each level only one cycle
    assign sclk_rise  = i_sclk & ~sclk_q;
    assign sclk_fall  = ~i_sclk & sclk_q;
    assign latch_rise = i_latch & ~latch_q;

    // ----------------------------------------------------------------
    // frame capture
    // ----------------------------------------------------------------

    // input shifter, msb first on rising serial clock
    // clock edges seen while the latch is high are dropped, and a frame
    // longer than 24 bits keeps only its last 24
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            in_sh_r <= `CDR_FRAME_RST;
        end else if (sclk_rise && !i_latch) begin
            in_sh_r <= {in_sh_r[`CDR_FRAME_W-2:0], i_din};
        end
    end

    // a frame is acted on when the latch pin rises
    // the strobe is combinational, so the write lands on the very edge
    // at which the raised latch is first seen
    assign frame_wr   = latch_rise;
    assign frame_addr = in_sh_r[`CDR_ADDR_MSB:`CDR_ADDR_LSB];
    assign frame_data = in_sh_r[`CDR_DATA_MSB:0];

    // twelve-bit variant drops the low nibble of written data
    // the stored nibble stays zero, so readback needs no second mask
    assign wr_mask = P_TWELVE_BIT ? `CDR_MASK_12B : `CDR_MASK_16B;
    assign wr_data = frame_data & wr_mask;                       // R19

    // ----------------------------------------------------------------
    // software reset
    // ----------------------------------------------------------------

    // reset bit sets for one cycle only, upper bits are ignored
    // the latch strobe lasts one cycle, so a latch held high cannot
    // repeat the reset; nothing is left for the host to clear
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            soft_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= frame_wr
                          && (frame_addr == `CDR_ADDR_RESET)      // R04
                          && frame_data[`CDR_RST_BIT];           // R07
        end
    end

    // common clear for every register and flag
    // clear wins over a monitor that is still raised; such a flag comes
    // back one edge later
    assign clr_all      = soft_rst_r;                            // R05
    assign o_soft_reset = soft_rst_r;                            // R06

    // ----------------------------------------------------------------
    // data and trim registers
    // ----------------------------------------------------------------

    // output code, unsigned straight binary
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || clr_all) begin
            output_code_r <= `CDR_WORD_RST;                      // R01
        end else if (frame_wr && frame_addr == `CDR_ADDR_DATA) begin
            output_code_r <= wr_data;
        end
    end

    // gain trim, unsigned
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || clr_all) begin
            gain_trim_r <= `CDR_WORD_RST;                        // R02
        end else if (frame_wr && frame_addr == `CDR_ADDR_GAIN) begin
            gain_trim_r <= wr_data;
        end
    end

    // offset trim, twos complement
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || clr_all) begin
            offset_trim_r <= `CDR_WORD_RST;                      // R03
        end else if (frame_wr && frame_addr == `CDR_ADDR_ZERO) begin
            offset_trim_r <= wr_data;
        end
    end

    // calibration enable, the only configuration bit kept here
    // the other configuration bits belong to blocks outside this bank
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || clr_all) begin
            calibration_enable_r <= 1'b0;
        end else if (frame_wr && frame_addr == `CDR_ADDR_CONFIG) begin
            calibration_enable_r <= frame_data[`CDR_CALIBRATION_ENABLE_BIT];               // R18
        end
    end

    // ----------------------------------------------------------------
    // alarm and slew status
    // ----------------------------------------------------------------
    // flags follow their monitors every cycle, so a fault still present
    // after a clear comes back on the very next edge

    // crc fault of the serial frame checker
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || clr_all) begin
            frame_crc_fault_r <= 1'b0;                           // R16
        end else begin
            frame_crc_fault_r <= i_crc_err;                      // R10 R17
        end
    end

    // watchdog expiry
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || clr_all) begin
            watchdog_fault_r <= 1'b0;                            // R16
        end else begin
            watchdog_fault_r <= i_wd_expired;                    // R11 R17
        end
    end

    // open circuit or compliance violation on the output
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || clr_all) begin
            output_load_fault_r <= 1'b0;                         // R16
        end else begin
            output_load_fault_r <= i_load_fault;                 // R12 R15
        end
    end

    // code ramp in progress
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || clr_all) begin
            slewing_active_r <= 1'b0;
        end else begin
            slewing_active_r <= i_slewing;                       // R13
        end
    end

    // die over temperature from the thermal comparator
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || clr_all) begin
            over_temp_fault_r <= 1'b0;                           // R16
        end else begin
            over_temp_fault_r <= i_over_temp;                    // R14 R15
        end
    end

    // status word, read only, upper bits zero
    // no write path reaches it, so a frame aimed at it changes nothing
    always_comb begin
        status                = '0;
        status[`CDR_ST_CRC]   = frame_crc_fault_r;
        status[`CDR_ST_WD]    = watchdog_fault_r;
        status[`CDR_ST_LOAD]  = output_load_fault_r;
        status[`CDR_ST_SLEW]  = slewing_active_r;
        status[`CDR_ST_TEMP]  = over_temp_fault_r;
        status_word           = {11'h000, status};               // R08 R09
    end

    assign o_fault_status = status;

    // ----------------------------------------------------------------
    // readback
    // ----------------------------------------------------------------

    // configuration word with only the enable bit populated
    always_comb begin
        config_word                 = `CDR_WORD_RST;
        config_word[`CDR_CALIBRATION_ENABLE_BIT] = calibration_enable_r;
    end

    // register chosen by the read frame
    // an unknown select returns zero rather than a stale word
    always_comb begin
        case (frame_data[`CDR_RD_SEL_W-1:0])
            `CDR_RD_STATUS: rd_word = status_word;               // R20
            `CDR_RD_DATA:   rd_word = output_code_r;
            `CDR_RD_CONFIG: rd_word = config_word;
            `CDR_RD_GAIN:   rd_word = gain_trim_r;
            `CDR_RD_ZERO:   rd_word = offset_trim_r;
            default:        rd_word = `CDR_WORD_RST;
        endcase
    end

    // next output shifter contents
    // a read frame loads the word at its latch edge and the host clocks it
    // out with the next frame, msb first, one bit per falling serial clock;
    // any other frame loads zeros so stale data never leaks out
    always_comb begin
        out_sh_nxt = out_sh_r;
        if (frame_wr) begin
            if (frame_addr == `CDR_ADDR_READ) begin
                out_sh_nxt = {8'h00, rd_word};
            end else begin
                out_sh_nxt = `CDR_FRAME_RST;
            end
        end else if (sclk_fall && !i_latch) begin
            out_sh_nxt = {out_sh_r[`CDR_FRAME_W-2:0], 1'b0};
        end
    end

    // output shifter, loaded at latch and shifted on falling clock
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || clr_all) begin
            out_sh_r <= `CDR_FRAME_RST;
        end else begin
            out_sh_r <= out_sh_nxt;
        end
    end

    // serial data out, msb of the shifter
    // taken from the next shifter value so the pin moves with the shifter
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || clr_all) begin
            sdo_r <= 1'b0;
        end else begin
            sdo_r <= out_sh_nxt[`CDR_FRAME_W-1];
        end
    end

    assign o_sdo = sdo_r;

    // ----------------------------------------------------------------
    // calibration datapath
    // ----------------------------------------------------------------

    // register contents to the calibration stage
    assign cal_bus.code   = output_code_r;
    assign cal_bus.gain   = gain_trim_r;
    assign cal_bus.offset = offset_trim_r;
    assign cal_bus.calibration_enable  = calibration_enable_r;

    // scaling and offset of the output code
    cdr_cal u_cal (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .bus     (cal_bus.cal)
    );

    // code delivered to the converter core
    // it lags the data register by one cycle through the calibration stage
    assign o_output_code        = cal_bus.cal_code;
    assign o_calibration_enable = calibration_enable_r;

endmodule : cdr_regs
`default_nettype wire

//--- verification/cdr_regs_monitor.sv
// assertion checker watching the ports of the dac register bank
`timescale 1ns/1ps
`default_nettype none
module cdr_regs_monitor #(
    parameter bit P_TWELVE_BIT = 1'b0
) (
    input wire logic                 i_mclk,
    input wire logic                 i_rst_n,
    input wire logic                 i_sclk,
    input wire logic                 i_din,
    input wire logic                 i_latch,
    input wire logic                 o_sdo,
    input wire logic                 i_crc_err,
    input wire logic                 i_wd_expired,
    input wire logic                 i_load_fault,
    input wire logic                 i_slewing,
    input wire logic                 i_over_temp,
    input wire cdr_pkg::cdr_word_t   o_output_code,
    input wire logic                 o_calibration_enable,
    input wire logic                 o_soft_reset,
    input wire cdr_pkg::cdr_status_t o_fault_status
);
    import cdr_pkg::*;
    logic       latch_q;
    logic       sclk_q;
    logic [2:0] quiet_cnt;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // cycles since the serial port last moved or a soft reset ran
    always_ff @(posedge i_mclk) begin
        latch_q <= i_latch;
        sclk_q  <= i_sclk;
        if (!i_rst_n || i_latch != latch_q || i_sclk != sclk_q || o_soft_reset)
            quiet_cnt <= 3'h0;
        else if (quiet_cnt != 3'h7)
            quiet_cnt <= quiet_cnt + 3'h1;
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    reset_zero_a: assert property ($rose(i_rst_n) |-> o_output_code == 16'h0000
        && o_fault_status == 5'h00 && !o_soft_reset) else $error("outputs not zero at reset");
    flag_follow_a: assert property ($past(i_rst_n, 2) && $past(i_rst_n) && !$past(o_soft_reset)
        |-> o_fault_status == $past({i_crc_err, i_wd_expired, i_load_fault, i_slewing,
        i_over_temp})) else $error("flags do not follow monitors");
    soft_pulse_a: assert property (o_soft_reset |=> !o_soft_reset)
        else $error("soft reset longer than one cycle");
    soft_cause_a: assert property (o_soft_reset |-> $past(i_latch) && !$past(i_latch, 2))
        else $error("soft reset without a frame");
    soft_clears_a: assert property (o_soft_reset |=> (!o_calibration_enable
        && o_fault_status == 5'h00) ##1 o_output_code == 16'h0000) else $error("soft reset left state");
    code_hold_a: assert property (quiet_cnt >= 3'h3 |-> $stable(o_output_code))
        else $error("code moved without a frame");
    calibration_enable_hold_a: assert property (quiet_cnt >= 3'h3 |-> $stable(o_calibration_enable))
        else $error("calibration enable moved without a frame");
    sdo_hold_a: assert property (quiet_cnt >= 3'h3 |-> $stable(o_sdo))
        else $error("readback moved without a clock");
    cover property (o_soft_reset);
    cover property (o_fault_status != 5'h00);
    cover property ($rose(o_calibration_enable));
endmodule : cdr_regs_monitor
bind cdr_regs cdr_regs_monitor #(.P_TWELVE_BIT(P_TWELVE_BIT)) u_cdr_mon (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sclk(i_sclk), .i_din(i_din), .i_latch(i_latch),
    .o_sdo(o_sdo), .i_crc_err(i_crc_err), .i_wd_expired(i_wd_expired),
    .i_load_fault(i_load_fault), .i_slewing(i_slewing), .i_over_temp(i_over_temp),
    .o_output_code(o_output_code), .o_calibration_enable(o_calibration_enable),
    .o_soft_reset(o_soft_reset), .o_fault_status(o_fault_status)
);
`default_nettype wire

//--- verification/cdr_host_model.sv
// host controller model driving the serial frame port
`timescale 1ns/1ps
`default_nettype none
module cdr_host_model (
    input  wire logic i_mclk,
    input  wire logic i_sdo,
    output var logic  o_sclk,
    output var logic  o_din,
    output var logic  o_latch
);
    // idle port: clock low, latch low
    initial begin
        o_sclk  = 1'b0;
        o_din   = 1'b1;
        o_latch = 1'b0;
    end
    // one frame msb first, readback bit taken before each rise
    task automatic xfer(input logic [23:0] frame, output logic [23:0] rx);
        for (int i = 23; i >= 0; i--) begin
            @(posedge i_mclk) o_din <= frame[i];
            repeat (2) @(posedge i_mclk);
            rx[i] = i_sdo;
            o_sclk <= 1'b1;
            repeat (2) @(posedge i_mclk);
            o_sclk <= 1'b0;
        end
        repeat (2) @(posedge i_mclk);
        o_latch <= 1'b1;
        repeat (2) @(posedge i_mclk);
        o_latch <= 1'b0;
        o_din   <= ~frame[0];
        repeat (3) @(posedge i_mclk);
    endtask : xfer
endmodule : cdr_host_model
`default_nettype wire

//--- verification/cdr_regs_tb.sv
// self-checking bench for the dac register bank
`timescale 1ns/1ps
`default_nettype none
`include "cdr_map.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module cdr_regs_tb;
    import cdr_pkg::*;
    logic        mclk;
    logic        rst_n;
    logic [4:0]  mon;
    wire         sclk, din, latch, sdo, calibration_enable, srst;
    cdr_word_t   code;
    cdr_word_t   code12;
    cdr_status_t fstat;
    int          error_cnt = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          srst_cyc = 0;
    cdr_host_model host (.i_mclk(mclk), .i_sdo(sdo), .o_sclk(sclk), .o_din(din), .o_latch(latch));
    cdr_regs #(.P_TWELVE_BIT(1'b0)) dut (
        .i_mclk(mclk), .i_rst_n(rst_n), .i_sclk(sclk), .i_din(din), .i_latch(latch),
        .o_sdo(sdo), .i_crc_err(mon[4]), .i_wd_expired(mon[3]), .i_load_fault(mon[2]),
        .i_slewing(mon[1]), .i_over_temp(mon[0]), .o_output_code(code),
        .o_calibration_enable(calibration_enable), .o_soft_reset(srst), .o_fault_status(fstat)
    );
    // twelve-bit variant on the same serial port, only its code is watched
    cdr_regs #(.P_TWELVE_BIT(1'b1)) dut_12b (
        .i_mclk(mclk), .i_rst_n(rst_n), .i_sclk(sclk), .i_din(din), .i_latch(latch),
        .o_sdo(), .i_crc_err(mon[4]), .i_wd_expired(mon[3]), .i_load_fault(mon[2]),
        .i_slewing(mon[1]), .i_over_temp(mon[0]), .o_output_code(code12),
        .o_calibration_enable(), .o_soft_reset(), .o_fault_status()
    );
    // clock, soft reset pulse length and hang guard
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (srst === 1'b1)
            srst_cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task automatic wr(input cdr_addr_t a, input cdr_word_t d);
        logic [23:0] rx;
        host.xfer({a, d}, rx);
    endtask : wr
    // read frame, then a no-op frame that clocks the word out
    task automatic rd(input logic [2:0] sel, output cdr_word_t w);
        logic [23:0] rx;
        host.xfer({`CDR_ADDR_READ, 13'h0000, sel}, rx);
        host.xfer(`CDR_FRAME_RST, rx);
        w = rx[15:0];
    endtask : rd
    task automatic t_reset();
        cdr_word_t w;
        `CHK("code", 16'h0000, code)
        rd(`CDR_RD_GAIN, w);
        `CHK("gain", 16'h0000, w)
        rd(`CDR_RD_ZERO, w);
        `CHK("zero", 16'h0000, w)
        $display("test reset done");
    endtask : t_reset
    task automatic t_regs();
        cdr_word_t w;
        wr(`CDR_ADDR_DATA, 16'hA5C3);
        `CHK("code", 16'hA5C3, code)
        `CHK("code 12b", 16'hA5C0, code12)
        wr(`CDR_ADDR_GAIN, 16'hFFFF);
        wr(`CDR_ADDR_ZERO, 16'h8001);
        wr(8'h03, 16'hFFFF);
        rd(`CDR_RD_GAIN, w);
        `CHK("gain", 16'hFFFF, w)
        rd(`CDR_RD_ZERO, w);
        `CHK("zero", 16'h8001, w)
        rd(`CDR_RD_DATA, w);
        `CHK("data", 16'hA5C3, w)
        rd(`CDR_RD_STATUS, w);
        `CHK("status", 16'h0000, w)
        $display("test registers done");
    endtask : t_regs
    // each monitor alone, read twice, then released
    task automatic t_flags();
        cdr_word_t w;
        for (int b = 0; b < 5; b++) begin
            mon <= 5'h01 << b;
            repeat (3) @(posedge mclk);
            `CHK("flag", 5'h01 << b, fstat)
            rd(`CDR_RD_STATUS, w);
            `CHK("status", 16'h0001 << b, w)
            rd(`CDR_RD_STATUS, w);
            `CHK("reread", 16'h0001 << b, w)
        end
        mon <= 5'h00;
        repeat (3) @(posedge mclk);
        `CHK("cleared", 5'h00, fstat)
        $display("test flags done");
    endtask : t_flags
    // gain 0 halves the code: 0x1000 -> 0x0800, plus 0x10; 8 -> 4, minus 16 clamps
    task automatic t_cal();
        wr(`CDR_ADDR_DATA, 16'h1000);
        wr(`CDR_ADDR_GAIN, 16'h0000);
        wr(`CDR_ADDR_ZERO, 16'h0010);
        wr(`CDR_ADDR_CONFIG, 16'h0020);
        `CHK("calibration_enable", 1'b1, calibration_enable)
        `CHK("cal code", 16'h0810, code)
        wr(`CDR_ADDR_DATA, 16'h0008);
        wr(`CDR_ADDR_ZERO, 16'hFFF0);
        `CHK("clamp", 16'h0000, code)
        $display("test calibration done");
    endtask : t_cal
    task automatic t_srst();
        cdr_word_t w;
        mon <= 5'h01;
        wr(`CDR_ADDR_ZERO, 16'h0003);
        wr(`CDR_ADDR_RESET, 16'hFFFE);
        `CHK("kept code", 16'h0007, code)
        `CHK("kept calibration_enable", 1'b1, calibration_enable)
        srst_cyc = 0;
        wr(`CDR_ADDR_RESET, 16'h0001);
        `CHK("pulse", 1, srst_cyc)
        `CHK("code", 16'h0000, code)
        `CHK("calibration_enable", 1'b0, calibration_enable)
        `CHK("reassert", 5'h01, fstat)
        rd(`CDR_RD_ZERO, w);
        `CHK("zero", 16'h0000, w)
        mon <= 5'h00;
        $display("test soft reset done");
    endtask : t_srst
    // main sequence
    initial begin
        rst_n = 1'b0;
        mon   = 5'h00;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_regs();
        t_flags();
        t_cal();
        t_srst();
        print_verdict();
    end
endmodule : cdr_regs_tb
`default_nettype wire
